// ==== dcap_consts.vh ====
`ifndef DCAP_CONSTS_VH
`define DCAP_CONSTS_VH
// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define DCAP_OFS_POWER    12'h000
`define DCAP_OFS_PATH     12'h004
`define DCAP_OFS_PORT     12'h008
`define DCAP_OFS_CLKSRC   12'h00C
`define DCAP_OFS_PLL      12'h010
`define DCAP_OFS_RATE     12'h014
`define DCAP_OFS_SYNC     12'h018
`define DCAP_OFS_STATUS   12'h01C
// ----------------------------------------
// field encodings
// ----------------------------------------
`define DCAP_SEL_OFF      2'h0
`define DCAP_SEL_LEFT     2'h1
`define DCAP_SEL_RIGHT    2'h2
`define DCAP_SEL_MONO     2'h3
`define DCAP_BIAS_OFF     2'h0
`define DCAP_BIAS_2V0     2'h1
`define DCAP_BIAS_2V5     2'h2
`define DCAP_BIAS_SUPPLY  2'h3
`define DCAP_FMT_I2S      2'h0
`define DCAP_FMT_DSP      2'h1
`define DCAP_FMT_RJ       2'h2
`define DCAP_FMT_LJ       2'h3
`define DCAP_VOL_INDEP    2'h0
`define DCAP_VOL_L_FOL_R  2'h1
`define DCAP_VOL_R_FOL_L  2'h2
// ----------------------------------------
// limits and reset values
// ----------------------------------------
`define DCAP_DIV_MIN      5'h02
`define DCAP_DIV_MAX      5'h11
`define DCAP_DIV_RESET    5'h02
`define DCAP_BCLK_DIV_RST 8'h04
`define DCAP_SLOT_BITS    8'h20
`define DCAP_QUARTER_MIN  8'h01
`endif

// ==== dcap_top.v ====
`timescale 1ns/10ps
`include "dcap_consts.vh"
module dcap_top (
  // clock and reset
  input  wire        clock,
  input  wire        resetn,
  // apb slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  // audio pins
  input  wire        mclk_in,
  input  wire        bit_clock_in,
  input  wire        word_clock_in,
  output reg         bit_clock_out,
  output reg         bit_clock_oe,
  output reg         word_clock_out,
  output reg         word_clock_oe,
  // converter drift report
  input  wire        delay_drift,
  // datapath and analog controls
  output reg         left_power_on,
  output reg         right_power_on,
  output reg  [1:0]  left_input_select,
  output reg  [1:0]  right_input_select,
  output reg  [6:0]  left_volume,
  output reg  [6:0]  right_volume,
  output reg         left_direct_driver,
  output reg         right_direct_driver,
  output reg         mixer_gain_enable_left,
  output reg         mixer_gain_enable_right,
  output reg  [1:0]  microphone_bias_level,
  output reg         soft_mute,
  // serial port and clock tree controls
  output reg  [1:0]  port_format,
  output reg  [1:0]  word_length,
  output reg  [7:0]  slot_offset,
  output reg         use_loop_clock,
  output reg         divider_input_is_bclk,
  output reg         loop_input_is_bclk,
  output reg  [4:0]  clock_divisor,
  output reg  [2:0]  front_divisor,
  output reg  [13:0] fractional_multiplier,
  output reg  [3:0]  second_scale,
  output reg  [3:0]  sample_rate_divisor,
  output reg         dual_rate,
  output reg         converter_clock_tick
);

  // ----------------------------------------
  // software-visible registers
  // ----------------------------------------
  reg        sw_pwr_l;
  reg        sw_pwr_r;
  reg [1:0]  sw_sel_l;
  reg [1:0]  sw_sel_r;
  reg [6:0]  sw_vol_l;
  reg [6:0]  sw_vol_r;
  reg [1:0]  sw_vol_mode;
  reg        sw_dir_l;
  reg        sw_dir_r;
  reg [1:0]  sw_bias;
  reg [1:0]  sw_fmt;
  reg [1:0]  sw_wlen;
  reg [7:0]  sw_bclk_div;
  reg [7:0]  sw_slot;
  reg        sw_master;
  reg        sw_keep_clk;
  reg        sw_use_loop;
  reg        sw_div_bclk;
  reg        sw_loop_bclk;
  reg [4:0]  sw_div;
  reg [2:0]  sw_front;
  reg [13:0] sw_frac;
  reg [3:0]  sw_scale;
  reg [3:0]  sw_rate_div;
  reg        sw_dual;
  reg        sw_resync_en;
  reg        sw_mute_en;
  reg        clk_update;
  reg        resync_seen;

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  reg [1:0] mclk_sync;
  reg [1:0] bclk_sync;
  reg [1:0] wclk_sync;
  reg [1:0] drift_sync;

  // two flops per external input
  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      mclk_sync  <= 2'h0;
      bclk_sync  <= 2'h0;
      wclk_sync  <= 2'h0;
      drift_sync <= 2'h0;
    end else begin
      mclk_sync  <= {mclk_sync[0], mclk_in};
      bclk_sync  <= {bclk_sync[0], bit_clock_in};
      wclk_sync  <= {wclk_sync[0], word_clock_in};
      drift_sync <= {drift_sync[0], delay_drift};
    end
  end

  wire mclk_s  = mclk_sync[1];
  wire bclk_s  = bclk_sync[1];
  wire drift_s = drift_sync[1];

  // ----------------------------------------
  // apb slave
  // ----------------------------------------
  wire apb_access = psel && penable && !pready;
  wire apb_wr     = apb_access && pwrite;
  wire hit        = (paddr[11:5] == 7'h00) && (paddr[1:0] == 2'h0);
  wire wr_clk     = apb_wr && hit &&
                    ((paddr == `DCAP_OFS_CLKSRC) || (paddr == `DCAP_OFS_PLL));
  wire div_ok     = (pwdata[8:4] >= `DCAP_DIV_MIN) && (pwdata[8:4] <= `DCAP_DIV_MAX);

  // register writes, one wait state per access
  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      pready       <= 1'b0;
      pslverr      <= 1'b0;
      sw_pwr_l     <= 1'b0;
      sw_pwr_r     <= 1'b0;
      sw_sel_l     <= `DCAP_SEL_OFF;
      sw_sel_r     <= `DCAP_SEL_OFF;
      sw_vol_l     <= 7'h00;
      sw_vol_r     <= 7'h00;
      sw_vol_mode  <= `DCAP_VOL_INDEP;
      sw_dir_l     <= 1'b0;
      sw_dir_r     <= 1'b0;
      sw_bias      <= `DCAP_BIAS_OFF;
      sw_fmt       <= `DCAP_FMT_I2S;
      sw_wlen      <= 2'h0;
      sw_bclk_div  <= `DCAP_BCLK_DIV_RST;
      sw_slot      <= 8'h00;
      sw_master    <= 1'b0;
      sw_keep_clk  <= 1'b0;
      sw_use_loop  <= 1'b0;
      sw_div_bclk  <= 1'b0;
      sw_loop_bclk <= 1'b0;
      sw_div       <= `DCAP_DIV_RESET;
      sw_front     <= 3'h1;
      sw_frac      <= 14'h0000;
      sw_scale     <= 4'h1;
      sw_rate_div  <= 4'h0;
      sw_dual      <= 1'b0;
      sw_resync_en <= 1'b0;
      sw_mute_en   <= 1'b0;
      clk_update   <= 1'b0;
    end else begin
      pready     <= apb_access;
      pslverr    <= apb_access && !hit;
      clk_update <= wr_clk;
      if (apb_wr && hit) begin
        case (paddr)
          `DCAP_OFS_POWER: begin
            sw_pwr_l <= pwdata[0];
            sw_pwr_r <= pwdata[1];
            sw_bias  <= pwdata[5:4];
          end
          `DCAP_OFS_PATH: begin
            sw_sel_l    <= pwdata[1:0];
            sw_sel_r    <= pwdata[3:2];
            sw_dir_l    <= pwdata[4];
            sw_dir_r    <= pwdata[5];
            sw_vol_mode <= pwdata[7:6];
            sw_vol_l    <= pwdata[14:8];
            sw_vol_r    <= pwdata[22:16];
          end
          `DCAP_OFS_PORT: begin
            sw_fmt      <= pwdata[1:0];
            sw_wlen     <= pwdata[3:2];
            sw_master   <= pwdata[4];
            sw_keep_clk <= pwdata[5];
            sw_bclk_div <= pwdata[15:8];
            sw_slot     <= pwdata[23:16];
          end
          `DCAP_OFS_CLKSRC: begin
            sw_use_loop  <= pwdata[0];
            sw_div_bclk  <= pwdata[1];
            sw_loop_bclk <= pwdata[2];
            if (div_ok) begin
              sw_div <= pwdata[8:4];
            end
          end
          `DCAP_OFS_PLL: begin
            sw_front <= pwdata[2:0];
            sw_scale <= pwdata[7:4];
            sw_frac  <= pwdata[29:16];
          end
          `DCAP_OFS_RATE: begin
            sw_rate_div <= pwdata[3:0];
            sw_dual     <= pwdata[4];
          end
          `DCAP_OFS_SYNC: begin
            sw_resync_en <= pwdata[0];
            sw_mute_en   <= pwdata[1];
          end
          default: begin
          end
        endcase
      end
    end
  end

  // read mux, registered
  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      prdata <= 32'h00000000;
    end else if (apb_access && !pwrite) begin
      case (paddr)
        `DCAP_OFS_POWER:  prdata <= {26'h0, sw_bias, 2'h0, sw_pwr_r, sw_pwr_l};
        `DCAP_OFS_PATH:   prdata <= {9'h0, sw_vol_r, 1'b0, sw_vol_l, sw_vol_mode,
                                     sw_dir_r, sw_dir_l, sw_sel_r, sw_sel_l};
        `DCAP_OFS_PORT:   prdata <= {8'h0, sw_slot, sw_bclk_div, 2'h0, sw_keep_clk,
                                     sw_master, sw_wlen, sw_fmt};
        `DCAP_OFS_CLKSRC: prdata <= {23'h0, sw_div, 1'b0, sw_loop_bclk, sw_div_bclk,
                                     sw_use_loop};
        `DCAP_OFS_PLL:    prdata <= {2'h0, sw_frac, 8'h0, sw_scale, 1'b0, sw_front};
        `DCAP_OFS_RATE:   prdata <= {27'h0, sw_dual, sw_rate_div};
        `DCAP_OFS_SYNC:   prdata <= {30'h0, sw_mute_en, sw_resync_en};
        `DCAP_OFS_STATUS: prdata <= {29'h0, resync_seen, soft_mute, use_loop_clock};
        default:          prdata <= 32'h00000000;
      endcase
    end
  end

  // ----------------------------------------
  // clock tree: glitch-free switchover
  // ----------------------------------------
  reg [4:0] div_count;
  reg       src_prev;
  wire      src_sel  = divider_input_is_bclk ? bclk_s : mclk_s;
  wire      src_rise = src_sel && !src_prev;
  wire      div_wrap = src_rise && (div_count >= clock_divisor - 5'h01);
  // settings move at a divider boundary or just after the write lands
  wire      clk_apply     = (div_wrap || clk_update) && !wr_clk;
  // source selection that holds once this edge has passed
  wire      next_use_loop = clk_apply ? sw_use_loop : use_loop_clock;

  // apply clock settings at a divider period boundary or the cycle after a clock register write
  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      use_loop_clock        <= 1'b0;
      divider_input_is_bclk <= 1'b0;
      loop_input_is_bclk    <= 1'b0;
      clock_divisor         <= `DCAP_DIV_RESET;
      front_divisor         <= 3'h1;
      fractional_multiplier <= 14'h0000;
      second_scale          <= 4'h1;
      div_count             <= 5'h00;
      src_prev              <= 1'b0;
      converter_clock_tick  <= 1'b0;
    end else begin
      src_prev <= src_sel;
      // integer divide of the divider input
      if (src_rise) begin
        div_count <= div_wrap ? 5'h00 : div_count + 5'h01;
      end
      // converter tick from divider path only when PLL bypassed
      // judged on the new selection so no tick leaks out as the loop path takes over
      converter_clock_tick <= div_wrap && !next_use_loop;
      if (clk_apply) begin
        divider_input_is_bclk <= sw_div_bclk;
        loop_input_is_bclk    <= sw_loop_bclk;
        use_loop_clock        <= sw_use_loop;
        clock_divisor         <= sw_div;
        front_divisor         <= sw_front;
        fractional_multiplier <= sw_frac;
        second_scale          <= sw_scale;
      end
    end
  end

  // ----------------------------------------
  // master clock generation
  // ----------------------------------------
  reg [7:0] bclk_count;
  reg [7:0] bit_count;
  wire      conv_on = sw_pwr_l || sw_pwr_r;
  wire      run_clk = sw_master && (conv_on || sw_keep_clk);

  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      bclk_count     <= 8'h00;
      bit_count      <= 8'h00;
      bit_clock_out  <= 1'b0;
      bit_clock_oe   <= 1'b0;
      word_clock_out <= 1'b0;
      word_clock_oe  <= 1'b0;
    end else begin
      bit_clock_oe  <= sw_master;
      word_clock_oe <= sw_master;
      // keep clocks running when powered down only while sw_keep_clk is set
      if (run_clk) begin
        if (bclk_count >= sw_bclk_div) begin
          bclk_count    <= 8'h00;
          bit_clock_out <= !bit_clock_out;
          if (bit_clock_out) begin
            bit_count <= (bit_count == 8'h3F) ? 8'h00 : bit_count + 8'h01;
            // DSP gives a one-bit frame pulse, others a half-frame level
            if (sw_fmt == `DCAP_FMT_DSP) begin
              word_clock_out <= (bit_count == 8'h3F);
            end else begin
              word_clock_out <= (bit_count >= 8'h1F) && (bit_count != 8'h3F);
            end
          end
        end else begin
          bclk_count <= bclk_count + 8'h01;
        end
      end else begin
        bclk_count     <= 8'h00;
        bit_count      <= 8'h00;
        bit_clock_out  <= 1'b0;
        word_clock_out <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // re-sync on drift
  // ----------------------------------------
  reg [7:0] mute_count;

  // drift beyond a quarter sample triggers re-sync
  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      soft_mute   <= 1'b0;
      mute_count  <= 8'h00;
      resync_seen <= 1'b0;
    end else begin
      if (sw_resync_en && drift_s && mute_count == 8'h00) begin
        mute_count  <= `DCAP_SLOT_BITS;
        resync_seen <= 1'b1;
      end else if (mute_count != 8'h00) begin
        mute_count <= mute_count - `DCAP_QUARTER_MIN;
      end else if (apb_wr && paddr == `DCAP_OFS_STATUS) begin
        resync_seen <= 1'b0;
      end
      soft_mute <= sw_mute_en && (mute_count != 8'h00);
    end
  end

  // ----------------------------------------
  // datapath outputs
  // ----------------------------------------
  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      left_power_on           <= 1'b0;
      right_power_on          <= 1'b0;
      left_input_select       <= `DCAP_SEL_OFF;
      right_input_select      <= `DCAP_SEL_OFF;
      left_volume             <= 7'h00;
      right_volume            <= 7'h00;
      left_direct_driver      <= 1'b0;
      right_direct_driver     <= 1'b0;
      mixer_gain_enable_left  <= 1'b1;
      mixer_gain_enable_right <= 1'b1;
      microphone_bias_level   <= `DCAP_BIAS_OFF;
      port_format             <= `DCAP_FMT_I2S;
      word_length             <= 2'h0;
      slot_offset             <= 8'h00;
      sample_rate_divisor     <= 4'h0;
      dual_rate               <= 1'b0;
    end else begin
      left_power_on         <= sw_pwr_l;
      right_power_on        <= sw_pwr_r;
      left_input_select     <= sw_sel_l;
      right_input_select    <= sw_sel_r;
      left_volume  <= (sw_vol_mode == `DCAP_VOL_L_FOL_R) ? sw_vol_r : sw_vol_l;
      right_volume <= (sw_vol_mode == `DCAP_VOL_R_FOL_L) ? sw_vol_l : sw_vol_r;
      left_direct_driver    <= sw_dir_l;
      right_direct_driver   <= sw_dir_r;
      mixer_gain_enable_left  <= !sw_dir_l;
      mixer_gain_enable_right <= !sw_dir_r;
      microphone_bias_level <= sw_bias;
      port_format           <= sw_fmt;
      word_length           <= sw_wlen;
      slot_offset           <= sw_slot;
      sample_rate_divisor   <= sw_rate_div;
      dual_rate             <= sw_dual;
    end
  end

endmodule // dcap_top

// ==== dcap_asserts.sv ====
`timescale 1ns/10ps
module dcap_asserts (
  // clock and reset
  input wire       clock,
  input wire       resetn,
  // apb handshake
  input wire       psel,
  input wire       penable,
  input wire       pready,
  input wire       pslverr,
  // watched controls
  input wire       bit_clock_oe,
  input wire       word_clock_oe,
  input wire       left_direct_driver,
  input wire       right_direct_driver,
  input wire       mixer_gain_enable_left,
  input wire       mixer_gain_enable_right,
  input wire       soft_mute,
  input wire       use_loop_clock,
  input wire       divider_input_is_bclk,
  input wire [4:0] clock_divisor,
  input wire       converter_clock_tick
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);
  // ----------------------------------------
  // access steps
  // ----------------------------------------
  sequence s_taken;
    psel && penable && !pready;
  endsequence
  sequence s_answer;
    pready && psel && penable;
  endsequence
  chk_apb_answer: assert property (s_taken |=> s_answer)
    else $error("access not answered after one wait state");
  chk_pready_pulse: assert property (pready |=> !pready)
    else $error("pready held longer than one cycle");
  chk_err_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  chk_mix_left: assert property (mixer_gain_enable_left == !left_direct_driver)
    else $error("left mixer gain active on direct route");
  chk_mix_right: assert property (mixer_gain_enable_right == !right_direct_driver)
    else $error("right mixer gain active on direct route");
  chk_oe_pair: assert property (bit_clock_oe == word_clock_oe)
    else $error("bit and word clock directions differ");
  chk_div_range: assert property (clock_divisor >= 5'h02 && clock_divisor <= 5'h11)
    else $error("divisor outside 2 to 17");
  chk_tick_bypass: assert property (converter_clock_tick |-> !use_loop_clock)
    else $error("divider tick while loop clock selected");
  chk_reset_defaults: assert property ($rose(resetn) |-> !divider_input_is_bclk
    && clock_divisor == 5'h02 && !bit_clock_oe)
    else $error("wrong clock defaults after reset");
  chk_mute_hold: assert property ($rose(soft_mute) |-> soft_mute [*8])
    else $error("soft mute dropped early in re-sync");
endmodule // dcap_asserts
bind dcap_top dcap_asserts u_chk (.clock(clock), .resetn(resetn), .psel(psel),
  .penable(penable), .pready(pready), .pslverr(pslverr), .bit_clock_oe(bit_clock_oe),
  .word_clock_oe(word_clock_oe), .left_direct_driver(left_direct_driver),
  .right_direct_driver(right_direct_driver), .mixer_gain_enable_left(mixer_gain_enable_left),
  .mixer_gain_enable_right(mixer_gain_enable_right), .soft_mute(soft_mute),
  .use_loop_clock(use_loop_clock), .divider_input_is_bclk(divider_input_is_bclk),
  .clock_divisor(clock_divisor), .converter_clock_tick(converter_clock_tick));

// ==== dcap_host.sv ====
`timescale 1ns/10ps
module dcap_host (
  // bench clock
  input  wire  clock,
  input  wire  drift_req,
  // device side of the clock pins
  input  wire  bclk_oe,
  input  wire  bclk_out,
  input  wire  wclk_oe,
  input  wire  wclk_out,
  // resolved pins
  output logic mclk,
  output logic bclk_pin,
  output logic wclk_pin,
  output logic drift
);
  logic       hb = 1'b0;
  logic       hw = 1'b0;
  logic [4:0] nb = 5'h00;
  logic [2:0] nd = 3'h0;
  // master clock for the reference rate
  initial mclk = 1'b0;
  always #6 mclk = ~mclk;
  // host bit and word clocks, 32 bits a half frame
  always #20 begin
    hb = ~hb;
    if (hb) begin
      nb = nb + 5'h01;
      if (nb == 5'h00) hw = ~hw;
    end
  end
  // device drives the pin only while its enable is high
  assign bclk_pin = bclk_oe ? bclk_out : hb;
  assign wclk_pin = wclk_oe ? wclk_out : hw;
  // drift report held for four cycles per request
  always @(posedge clock) begin
    if (drift_req) nd <= 3'h4;
    else if (nd != 3'h0) nd <= nd - 3'h1;
  end
  assign drift = (nd != 3'h0);
endmodule // dcap_host

// ==== dcap_top_tb.sv ====
`timescale 1ns/10ps
`include "dcap_consts.vh"
module dcap_top_tb;
  logic clock = 1'b0, resetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, dreq = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000, prdata;
  logic pready, pslverr, mclk, bpin, wpin, drift, bco, bcoe, wco, wcoe, lp, rp, ldd, rdd;
  logic mgl, mgr, smute, ulc, dib, lib, dual, tick, e, pb;
  logic [1:0] lis, ris, bias, fmt, wlen;
  logic [6:0] lv, rv;
  logic [7:0] slot;
  logic [4:0] cdiv;
  logic [2:0] fdiv;
  logic [13:0] frac;
  logic [3:0] scale, rdiv;
  logic [32:0] q[$], n;
  int n_mismatch = 0, samples_checked = 0, i, k, c;
  logic [6:0] vl, vr;
  always #4 clock = ~clock;
  dcap_host host_u (.clock(clock), .drift_req(dreq), .bclk_oe(bcoe), .bclk_out(bco),
    .wclk_oe(wcoe), .wclk_out(wco), .mclk(mclk), .bclk_pin(bpin), .wclk_pin(wpin), .drift(drift));
  dcap_top dut_u (.clock(clock), .resetn(resetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .mclk_in(mclk), .bit_clock_in(bpin), .word_clock_in(wpin),
    .bit_clock_out(bco), .bit_clock_oe(bcoe), .word_clock_out(wco), .word_clock_oe(wcoe),
    .delay_drift(drift), .left_power_on(lp), .right_power_on(rp), .left_input_select(lis),
    .right_input_select(ris), .left_volume(lv), .right_volume(rv), .left_direct_driver(ldd),
    .right_direct_driver(rdd), .mixer_gain_enable_left(mgl), .mixer_gain_enable_right(mgr),
    .microphone_bias_level(bias), .soft_mute(smute), .port_format(fmt), .word_length(wlen),
    .slot_offset(slot), .use_loop_clock(ulc), .divider_input_is_bclk(dib),
    .loop_input_is_bclk(lib), .clock_divisor(cdiv), .front_divisor(fdiv),
    .fractional_multiplier(frac), .second_scale(scale), .sample_rate_divisor(rdiv),
    .dual_rate(dual), .converter_clock_tick(tick));
  // ----------------------------------------
  // reporting and bus tasks
  // ----------------------------------------
  task automatic miss(input string m);
    n_mismatch++;
    $display("unexpected at %0t: %s", $time, m);
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] x, input string m);
    samples_checked++;
    if (g !== x) miss(m);
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d; penable <= 1'b0;
    @(posedge clock);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clock);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (k >= 50) begin
      miss("no pready");
      give_verdict;
    end
    e = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    @(posedge clock);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
    chk(e, 1'b0, "write refused");
  endtask
  task automatic rd(input logic [11:0] a, input logic [32:0] x);
    q.push_back(x);
    apb(1'b0, a, 32'h00000000);
  endtask
  // read results against the oldest note
  always @(posedge clock) begin
    if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1 && pwrite === 1'b0) begin
      if (q.size() == 0) miss("read with no note");
      else begin
        n = q.pop_front();
        samples_checked++;
        if (pslverr !== n[32] || (!n[32] && prdata !== n[31:0])) miss("read data");
      end
    end
  end
  // hang guard
  initial begin
    #80000;
    miss("timeout");
    give_verdict;
  end
  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    void'($urandom(51));
    repeat (10) @(posedge clock);
    resetn <= 1'b1;
    @(posedge clock);
    chk({dib, bcoe, wcoe, mgl, mgr, cdiv}, {5'h03, 5'h02}, "reset state");
    $display("test reset done");
    for (i = 0; i < 4; i++) begin
      wr(`DCAP_OFS_POWER, (i << 4) | i);
      chk({bias, rp, lp}, {i[1:0], i[1:0]}, "power or bias");
      rd(`DCAP_OFS_POWER, (i << 4) | i);
    end
    $display("test power done");
    for (c = 0; c < 3; c++) for (i = 0; i < 4; i++) begin
      vl = $urandom; vr = $urandom;
      wr(`DCAP_OFS_PATH, {vr, 1'b0, vl, c[1:0], i[1:0], 2'(3 - i), i[1:0]});
      chk({lis, ris, ldd, rdd, mgl, mgr}, {i[1:0], 2'(3 - i), i[0], i[1], ~i[0], ~i[1]},
        "path select");
      chk({lv, rv}, {c == 1 ? vr : vl, c == 2 ? vl : vr}, "volume track");
    end
    $display("test path done");
    wr(`DCAP_OFS_POWER, 32'h00000000);
    for (i = 0; i < 4; i++) begin
      vl = $urandom;
      wr(`DCAP_OFS_PORT, {8'h00, 1'b0, vl, 8'h04, 2'b00, i[1], i[0], 2'(3 - i), i[1:0]});
      chk({fmt, wlen, slot, bcoe, wcoe}, {i[1:0], 2'(3 - i), 1'b0, vl, i[0], i[0]},
        "port setup");
      c = 0;
      pb = bco;
      repeat (64) begin
        @(posedge clock);
        if (bco !== pb) c++;
        pb = bco;
      end
      if (i == 3) chk(c > 0, 1'b1, "clocks stopped while down");
      if (i == 1) chk(c == 0, 1'b1, "clocks ran while down");
      if (i == 3) chk(wco, 1'b0, "word clock early in frame");
    end
    wr(`DCAP_OFS_PORT, 32'h00000400);
    $display("test port done");
    wr(`DCAP_OFS_CLKSRC, 32'h00000112);
    wr(`DCAP_OFS_CLKSRC, 32'h00000122);
    repeat (400) @(posedge clock);
    chk({ulc, dib, lib, cdiv}, {3'h2, 5'h11}, "divider kept");
    c = 0;
    repeat (300) @(posedge clock) if (tick === 1'b1) c++;
    chk(c > 0, 1'b1, "no divided ticks");
    wr(`DCAP_OFS_CLKSRC, 32'h00000025);
    vl = $urandom; vr = $urandom;
    wr(`DCAP_OFS_PLL, {2'b00, vl, vr, 8'h00, vr[3:0], 1'b0, vl[2:0]});
    wr(`DCAP_OFS_RATE, {27'h0, vl[4:0]});
    repeat (400) @(posedge clock);
    chk({ulc, dib, lib, cdiv}, {3'h5, 5'h02}, "loop select");
    chk({fdiv, scale, frac}, {vl[2:0], vr[3:0], vl, vr}, "loop params");
    chk({rdiv, dual}, {vl[3:0], vl[4]}, "rate setup");
    rd(`DCAP_OFS_STATUS, 33'h000000001);
    $display("test clocks done");
    for (i = 3; i > 0; i -= 2) begin
      wr(`DCAP_OFS_SYNC, i);
      wr(`DCAP_OFS_STATUS, 32'h00000000);
      dreq <= 1'b1;
      @(posedge clock);
      dreq <= 1'b0;
      c = 0;
      repeat (60) @(posedge clock) if (smute === 1'b1) c++;
      chk(c > 0, i == 3, "soft mute during re-sync");
      rd(`DCAP_OFS_STATUS, 33'h000000005);
    end
    $display("test resync done");
    apb(1'b1, 12'h020, 32'hFFFFFFFF);
    chk(e, 1'b1, "unmapped write");
    rd(12'h002, 33'h100000000);
    rd(`DCAP_OFS_PORT, 33'h000000400);
    $display("test refusal done");
    give_verdict;
  end
endmodule // dcap_top_tb
